// file: bench/msr_master_model.sv
// fieldbus master model issuing parameter reads by address
// assumes the drive takes a one-cycle request on rising clk_sys
module msr_master_model (
  // clock
  input  wire logic        clk_sys,
  // request
  output logic             rd_en,
  output logic      [15:0] rd_addr,
  // answer
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        rd_err
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rd_en = 1'b0;
    rd_addr = 16'h0000;
  end
  // one read; address inverted once released
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic v, output logic e);
    @(negedge clk_sys);
    rd_en = 1'b1;
    rd_addr = a;
    @(posedge clk_sys);
    @(negedge clk_sys);
    rd_en = 1'b0;
    rd_addr = ~a;
    d = rd_data;
    v = rd_valid;
    e = rd_err;
  endtask
endmodule

// file: bench/msr_top_monitor.sv
// checker for the monitor status register bank
// assumes bind to msr_top, one clock domain
module msr_top_monitor (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        clk_en,
  // watched inputs
  input wire logic        dc_bus_low,
  input wire logic [1:0]  safe_torque_off_inputs,
  input wire logic        fault_clr,
  input wire logic        rd_en,
  input wire logic [15:0] rd_addr,
  // watched outputs
  input wire logic [31:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        rd_err,
  input wire logic [31:0] monitor_signals_live,
  input wire logic [31:0] monitor_signals_saved
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire rd_go = rd_en && clk_en;
  wire rd_live = rd_go && rd_addr == msr_pkg::ADDR_LIVE;
  wire rd_saved = rd_go && rd_addr == msr_pkg::ADDR_SAVED;
  a_reserved_zero:
    assert property (((monitor_signals_live | monitor_signals_saved) & ~msr_pkg::USED_MASK) == 32'h0)
    else $error("reserved bit set");
  a_valid_after_read:
    assert property (rd_go |=> rd_valid) else $error("no read answer");
  a_live_read_data:
    assert property (rd_live |=> !rd_err && rd_data == $past(monitor_signals_live)) else $error("live read wrong");
  a_saved_read_data:
    assert property (rd_saved |=> !rd_err && rd_data == $past(monitor_signals_saved)) else $error("saved read wrong");
  a_unmapped_err:
    assert property (rd_go && !rd_live && !rd_saved |=> rd_err && rd_data == 32'h0) else $error("unmapped read");
  a_saved_covers_live:
    assert property (clk_en |=> ($past(monitor_signals_live) & ~monitor_signals_saved) == 32'h0)
    else $error("saved missed live bit");
  a_saved_holds:
    assert property (clk_en && !fault_clr |=> ($past(monitor_signals_saved) & ~monitor_signals_saved) == 32'h0)
    else $error("saved bit dropped");
  a_dc_low_bit:
    assert property (clk_en |=> monitor_signals_live[13] == $past(dc_bus_low)) else $error("dc low bit");
  a_sto_bits:
    assert property (clk_en |=> monitor_signals_live[11:10] == ~$past(safe_torque_off_inputs)) else $error("sto bits");
  a_clear_drops:
    assert property (clk_en && fault_clr |=> monitor_signals_saved == $past(monitor_signals_live))
    else $error("saved not cleared");
  a_frozen_when_off:
    assert property (!clk_en |=> $stable(monitor_signals_live) && $stable(monitor_signals_saved) && $stable(rd_data)
                     && $stable(rd_valid) && $stable(rd_err))
    else $error("state moved while disabled");
endmodule
bind msr_top msr_top_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .dc_bus_low(dc_bus_low),
  .safe_torque_off_inputs(safe_torque_off_inputs), .fault_clr(fault_clr), .rd_en(rd_en), .rd_addr(rd_addr),
  .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err), .monitor_signals_live(monitor_signals_live),
  .monitor_signals_saved(monitor_signals_saved));

// file: bench/msr_top_test.sv
// self-checking bench for the monitor status register bank
// assumes msr_top, the master model and the bound checker
module msr_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst, clk_en, fault_clr, rd_en, rd_valid, rd_err, v, e;
  logic [26:0] cond;
  logic [31:0] rd_data, d, acc, live_word, saved_word;
  logic [15:0] rd_addr;
  int          bad_count, num_checks, cyc;
  int          bitpos [27] = '{0, 1, 1, 1, 2, 3, 4, 5, 6,
                               8, 13, 14, 15, 16, 17, 18,
                               20, 21, 22, 23, 26, 27, 28, 30, 31,
                               10, 11};
  msr_top DUT (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .general_error(cond[0]),
    .positive_limit_switch(cond[1]), .negative_limit_switch(cond[2]), .reference_switch(cond[3]),
    .out_of_range(cond[4]), .quick_stop_fieldbus(cond[5]), .mode_error(cond[6]), .rs485_fault(cond[7]),
    .fieldbus_fault(cond[8]), .following_error(cond[9]), .dc_bus_low(cond[10]), .dc_bus_high(cond[11]),
    .mains_phase_missing(cond[12]), .encoder_fault(cond[13]), .motor_overtemp(cond[14]),
    .power_stage_overtemp(cond[15]), .module_fault(cond[19:16]), .motor_connection_fault(cond[20]),
    .motor_overcurrent(cond[21]), .ref_freq_high(cond[22]), .startup_fault(cond[23]), .system_error(cond[24]),
    .safe_torque_off_inputs(~cond[26:25]), .fault_clr(fault_clr), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err), .monitor_signals_live(live_word),
    .monitor_signals_saved(saved_word));
  msr_master_model m (.clk_sys(clk_sys), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_err(rd_err));
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [15:0] a, input logic [31:0] x, input logic xe);
    m.rd(a, d, v, e);
    cmp({v, e, d}, {1'b1, xe, x});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    fault_clr = 1'b0;
    cond = '0;
    acc = '0;
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    chk(msr_pkg::ADDR_LIVE, 32'h0, 1'b0);
    chk(msr_pkg::ADDR_SAVED, 32'h0, 1'b0);
    for (int k = 0; k < 27; k++) begin
      cond = 27'h1 << k;
      acc[bitpos[k]] = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk(msr_pkg::ADDR_LIVE, 32'h1 << bitpos[k], 1'b0);
      chk(msr_pkg::ADDR_SAVED, acc, 1'b0);
    end
    cond = '0;
    repeat (2) @(negedge clk_sys);
    chk(msr_pkg::ADDR_LIVE, 32'h0, 1'b0);
    chk(msr_pkg::ADDR_SAVED, 32'hdcf7_ed7f, 1'b0);
    cond = 27'h400;
    fault_clr = 1'b1;
    repeat (3) @(negedge clk_sys);
    fault_clr = 1'b0;
    chk(msr_pkg::ADDR_SAVED, 32'h0000_2000, 1'b0);
    clk_en = 1'b0;
    cond = 27'h1;
    repeat (3) @(negedge clk_sys);
    cmp({live_word, saved_word}, {32'h0000_2000, 32'h0000_2000});
    clk_en = 1'b1;
    @(negedge clk_sys);
    cmp({live_word, saved_word}, {32'h0000_0001, 32'h0000_2000});
    cond = '0;
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    cmp({live_word, saved_word}, 64'h0);
    chk(msr_pkg::ADDR_SAVED, 32'h0, 1'b0);
    chk(msr_pkg::ADDR_LIVE, 32'h0, 1'b0);
    chk(16'h1c0f, 32'h0, 1'b1);
    summarize();
  end
endmodule

// file: design/msr_latch.sv
// sticky copy of the live monitor word
// assumes clear pulse from the fault-reset logic, synchronous to clk_sys
module msr_latch (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clk_en,
  // control
  input  wire logic fault_clr,
  // words
  msr_sig_if.lat    sig
);
  logic [31:0] saved_reg;
  logic [31:0] saved_next;

  // set wins over clear
  assign saved_next = (fault_clr ? 32'h0000_0000 : saved_reg) | (sig.live & msr_pkg::USED_MASK);
  assign sig.saved  = saved_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      saved_reg <= msr_pkg::RESET_VAL;
    else if (clk_en)
      saved_reg <= saved_next;
  end
endmodule

// file: design/msr_pkg.sv
// package for the monitor signal status registers
// assumes a parameter-address read port supplied by the drive's parameter engine
package msr_pkg;
  localparam logic [15:0] ADDR_LIVE  = 16'h1c0e;
  localparam logic [15:0] ADDR_SAVED = 16'h1c10;
  localparam logic [31:0] RESET_VAL  = 32'h0000_0000;
  localparam int          BIT_GEN_ERR     = 0;
  localparam int          BIT_HW_LIMIT    = 1;
  localparam int          BIT_OUT_RANGE   = 2;
  localparam int          BIT_QUICK_STOP  = 3;
  localparam int          BIT_MODE_ERR    = 4;
  localparam int          BIT_RS485       = 5;
  localparam int          BIT_FIELDBUS    = 6;
  localparam int          BIT_FOLLOW_ERR  = 8;
  localparam int          BIT_STO_A       = 10;
  localparam int          BIT_STO_B       = 11;
  localparam int          BIT_DC_LOW      = 13;
  localparam int          BIT_DC_HIGH     = 14;
  localparam int          BIT_PHASE_MISS  = 15;
  localparam int          BIT_ENCODER     = 16;
  localparam int          BIT_OT_MOTOR    = 17;
  localparam int          BIT_OT_POWER    = 18;
  localparam int          BIT_MEM_CARD    = 20;
  localparam int          BIT_OPT_FBUS    = 21;
  localparam int          BIT_OPT_ENC     = 22;
  localparam int          BIT_OPT_SAFE    = 23;
  localparam int          BIT_MOTOR_CONN  = 26;
  localparam int          BIT_OVERCURRENT = 27;
  localparam int          BIT_REF_FREQ    = 28;
  localparam int          BIT_STARTUP     = 30;
  localparam int          BIT_SYS_ERR     = 31;
  // positions that carry a condition; all others read zero
  localparam logic [31:0] USED_MASK = 32'hdcf7_ed7f;
endpackage

// file: design/msr_read.sv
// parameter-address decode for the two read-only words
// assumes a one-cycle read strobe with address
module msr_read (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // request
  input  wire logic        rd_en,
  input  wire logic [15:0] rd_addr,
  // answer
  output logic      [31:0] rd_data,
  output logic             rd_valid,
  output logic             rd_err,
  // words
  msr_sig_if.rd            sig
);
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction

  logic        hit_live;
  logic        hit_saved;
  logic [31:0] sel_word;

  assign hit_live  = hit(rd_addr, msr_pkg::ADDR_LIVE);
  assign hit_saved = hit(rd_addr, msr_pkg::ADDR_SAVED);
  assign sel_word  = hit_live ? sig.live : (hit_saved ? sig.saved : 32'h0000_0000);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data  <= 32'h0000_0000;
      rd_valid <= 1'b0;
      rd_err   <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= rd_en;
      rd_err   <= rd_en & ~(hit_live | hit_saved);
      if (rd_en)
        rd_data <= sel_word;
    end
  end
endmodule

// file: design/msr_sig_if.sv
// interface carrying the live and saved monitor words between modules
// assumes one clock domain
interface msr_sig_if;
  logic [31:0] live;
  logic [31:0] saved;
  modport src (output live, input saved);
  modport lat (input live, output saved);
  modport rd  (input live, input saved);
endinterface

// file: design/msr_top.sv
// monitor signal status register bank: live and saved words
// assumes condition inputs synchronous to clk_sys, active high except safe_torque_off_inputs, which are active low
module msr_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // monitored conditions
  input  wire logic        general_error,
  input  wire logic        positive_limit_switch,
  input  wire logic        negative_limit_switch,
  input  wire logic        reference_switch,
  input  wire logic        out_of_range,
  input  wire logic        quick_stop_fieldbus,
  input  wire logic        mode_error,
  input  wire logic        rs485_fault,
  input  wire logic        fieldbus_fault,
  input  wire logic        following_error,
  input  wire logic [1:0]  safe_torque_off_inputs,
  input  wire logic        dc_bus_low,
  input  wire logic        dc_bus_high,
  input  wire logic        mains_phase_missing,
  input  wire logic        encoder_fault,
  input  wire logic        motor_overtemp,
  input  wire logic        power_stage_overtemp,
  input  wire logic [3:0]  module_fault,
  input  wire logic        motor_connection_fault,
  input  wire logic        motor_overcurrent,
  input  wire logic        ref_freq_high,
  input  wire logic        startup_fault,
  input  wire logic        system_error,
  // fault reset
  input  wire logic        fault_clr,
  // parameter read port
  input  wire logic        rd_en,
  input  wire logic [15:0] rd_addr,
  output logic      [31:0] rd_data,
  output logic             rd_valid,
  output logic             rd_err,
  // direct views
  output logic      [31:0] monitor_signals_live,
  output logic      [31:0] monitor_signals_saved
);
  msr_sig_if sig ();

  logic [31:0] live_raw;
  logic [31:0] live_reg;

  // active-high condition map, 1 = activated
  always_comb begin
    live_raw = 32'h0000_0000;
    live_raw[msr_pkg::BIT_GEN_ERR]     = general_error;
    live_raw[msr_pkg::BIT_HW_LIMIT]    = positive_limit_switch | negative_limit_switch | reference_switch;
    live_raw[msr_pkg::BIT_OUT_RANGE]   = out_of_range;
    live_raw[msr_pkg::BIT_QUICK_STOP]  = quick_stop_fieldbus;
    live_raw[msr_pkg::BIT_MODE_ERR]    = mode_error;
    live_raw[msr_pkg::BIT_RS485]       = rs485_fault;
    live_raw[msr_pkg::BIT_FIELDBUS]    = fieldbus_fault;
    live_raw[msr_pkg::BIT_FOLLOW_ERR]  = following_error;
    live_raw[msr_pkg::BIT_STO_A]       = ~safe_torque_off_inputs[0];
    live_raw[msr_pkg::BIT_STO_B]       = ~safe_torque_off_inputs[1];
    live_raw[msr_pkg::BIT_DC_LOW]      = dc_bus_low;
    live_raw[msr_pkg::BIT_DC_HIGH]     = dc_bus_high;
    live_raw[msr_pkg::BIT_PHASE_MISS]  = mains_phase_missing;
    live_raw[msr_pkg::BIT_ENCODER]     = encoder_fault;
    live_raw[msr_pkg::BIT_OT_MOTOR]    = motor_overtemp;
    live_raw[msr_pkg::BIT_OT_POWER]    = power_stage_overtemp;
    live_raw[msr_pkg::BIT_MEM_CARD]    = module_fault[0];
    live_raw[msr_pkg::BIT_OPT_FBUS]    = module_fault[1];
    live_raw[msr_pkg::BIT_OPT_ENC]     = module_fault[2];
    live_raw[msr_pkg::BIT_OPT_SAFE]    = module_fault[3];
    live_raw[msr_pkg::BIT_MOTOR_CONN]  = motor_connection_fault;
    live_raw[msr_pkg::BIT_OVERCURRENT] = motor_overcurrent;
    live_raw[msr_pkg::BIT_REF_FREQ]    = ref_freq_high;
    live_raw[msr_pkg::BIT_STARTUP]     = startup_fault;
    live_raw[msr_pkg::BIT_SYS_ERR]     = system_error;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      live_reg <= msr_pkg::RESET_VAL;
    else if (clk_en)
      live_reg <= live_raw & msr_pkg::USED_MASK;
  end

  // one map feeds both words
  assign sig.live = live_reg;

  msr_latch u_latch (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clk_en    (clk_en),
    .fault_clr (fault_clr),
    .sig       (sig)
  );

  msr_read u_read (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clk_en   (clk_en),
    .rd_en    (rd_en),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data),
    .rd_valid (rd_valid),
    .rd_err   (rd_err),
    .sig      (sig)
  );

  assign monitor_signals_live  = live_reg;
  assign monitor_signals_saved = sig.saved;
endmodule
